// ### inc/sps_pkg.sv
// Contract
// - reset input high returns the sequencer to its idle state
// - first strobe fall with select low powers up and acquires; select high ignored
// - second strobe fall starts converting the acquired sample
// - third strobe fall with select high drives the result onto the bus
// - acquisition ends exactly at the second strobe fall, sample then held
// - after conversion enter standby or shutdown automatically, per latched select
// - second strobe fall to end-of-conversion fall within 4.7 us
// - reset pulsed with strobe high; next strobe fall begins acquisition
// - result is a 14-bit three-state word, bit 0 least significant
// - approximation steps timed by an internal clock, no host clock
// - end-of-conversion output goes low once conversion finishes
// - select high at second fall means shutdown, low means standby
// - data outputs stay high impedance during acquisition and conversion
// - strobe rise after the read edge floats the bus and awaits next cycle
package sps_pkg;

   // ***********************************************
   // widths and timing
   // ***********************************************
   localparam int RES_W = 14;
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CONV_MAX_NS_X10 = 47;     // 4.7 us, in tenths of a microsecond
   // longest time rounds down to whole cycles
   localparam int CONV_MAX_CYC = (CONV_MAX_NS_X10 * 100000) / CLK_PERIOD_PS;
   localparam int SAR_STEP_DIV = 32;        // clock cycles per approximation step
   localparam int WAKE_MIN_MS = 6;
   // cycles per millisecond first, so the product stays inside 32 bits
   localparam int WAKE_MIN_CYC = WAKE_MIN_MS * (1000000000 / CLK_PERIOD_PS);

   localparam logic [RES_W-1:0] RESULT_RST = 14'h0000;
   localparam logic [1:0] PHASE_ACQ = 2'h0;
   localparam logic [1:0] PHASE_CONV = 2'h1;
   localparam logic [1:0] PHASE_READ = 2'h2;

   typedef enum {ST_IDLE, ST_ACQ, ST_CONV, ST_DONE, ST_READ} sps_state_e;

   // power state shown to the analog side
   typedef struct packed {
      logic powered;     // core powered up
      logic ref_on;      // reference and buffer powered
      logic track;       // track-and-hold closed
   } sps_power_s;

endpackage

// ### src/sps_sar_engine.sv
`timescale 1ns/1ps
module sps_sar_engine #(
   parameter int RES_W = 14,
   parameter int STEP_DIV = 32
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_start,
   input wire logic i_cmp_hi,
   output logic [RES_W-1:0] o_trial,
   output logic [RES_W-1:0] o_result,
   output logic o_done
);
   localparam int DW = $clog2(STEP_DIV);
   localparam int BW = $clog2(RES_W + 1);

   logic [DW-1:0] div_r, div_nxt;
   logic [BW-1:0] bit_r, bit_nxt;
   logic busy_r, busy_nxt;
   logic [RES_W-1:0] acc_r, acc_nxt;
   logic done_r, done_nxt;
   logic step;

   // ***********************************************
   // internal step clock and binary search
   // ***********************************************
   // one-cycle step enable from a local divider, no host clock needed
   assign step = busy_r && (div_r == DW'(STEP_DIV - 1));
   assign o_trial = acc_r | (busy_r ? (RES_W'(1) << (bit_r - BW'(1))) : '0);

   // next values of the search
   always_comb begin
      div_nxt = busy_r ? div_r + DW'(1) : '0;
      if (step)
         div_nxt = '0;
      bit_nxt = bit_r;
      busy_nxt = busy_r;
      acc_nxt = acc_r;
      done_nxt = 1'b0;
      if (i_start) begin
         busy_nxt = 1'b1;
         bit_nxt = BW'(RES_W);
         acc_nxt = '0;
         div_nxt = '0;
      end else if (step) begin
         // keep the trial bit when the held sample is not below it
         if (i_cmp_hi)
            acc_nxt = o_trial;
         bit_nxt = bit_r - BW'(1);
         if (bit_r == BW'(1)) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   // registers
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         div_r <= '0;
         bit_r <= '0;
         busy_r <= 1'b0;
         acc_r <= '0;
         done_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         busy_r <= busy_nxt;
         acc_r <= acc_nxt;
         done_r <= done_nxt;
      end
   end

   assign o_result = acc_r;
   assign o_done = done_r;
endmodule

// ### src/sps_sequencer.sv
`timescale 1ns/1ps
module sps_sequencer #(
   parameter int RES_W = sps_pkg::RES_W,
   parameter int STEP_DIV = sps_pkg::SAR_STEP_DIV
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,                      // reset pin, active high
   input wire logic i_start_n,                   // convert-start strobe
   input wire logic i_rd_conv,                   // high read, low convert
   input wire logic i_cmp_hi,                    // comparator: sample >= trial
   output logic [RES_W-1:0] o_result_bus_o,      // result_bit_msb .. result_bit_lsb
   output logic [RES_W-1:0] o_result_bus_oe,
   output logic o_eoc_n,
   output logic [RES_W-1:0] o_trial_dac,
   output sps_pkg::sps_power_s o_power,
   output logic [1:0] o_phase
);
   import sps_pkg::*;

   sps_state_e state_r, state_nxt;
   logic strobe_d_r;
   logic fall, rise;
   logic shut_r, shut_nxt;
   logic [RES_W-1:0] dout_r, dout_nxt;
   logic oe_r, oe_nxt;
   logic eoc_n_r, eoc_n_nxt;
   logic [1:0] phase_r, phase_nxt;
   sps_power_s pwr_r, pwr_nxt;
   logic [RES_W-1:0] trial_r;
   logic sar_start;
   logic [RES_W-1:0] sar_trial, sar_result;
   logic sar_done;

   // ***********************************************
   // strobe edge detection
   // ***********************************************
   // strobe is taken as synchronous; one flop of history gives the edges
   // history resets high, so a strobe already low at release counts as a fall
   always_ff @(posedge i_ref_clk) begin
      if (i_srst)
         strobe_d_r <= 1'b1;
      else
         strobe_d_r <= i_start_n;
   end
   assign fall = strobe_d_r && !i_start_n;
   assign rise = !strobe_d_r && i_start_n;

   // ***********************************************
   // approximation engine
   // ***********************************************
   sps_sar_engine #(
      .RES_W(RES_W),
      .STEP_DIV(STEP_DIV)
   ) u_sar (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_start(sar_start),
      .i_cmp_hi(i_cmp_hi),
      .o_trial(sar_trial),
      .o_result(sar_result),
      .o_done(sar_done)
   );

   // conversion begins on the edge that ends acquisition
   assign sar_start = (state_r == ST_ACQ) && fall;

   // ***********************************************
   // sequencer next state
   // ***********************************************
   always_comb begin
      state_nxt = state_r;
      shut_nxt = shut_r;
      dout_nxt = dout_r;
      oe_nxt = oe_r;
      eoc_n_nxt = eoc_n_r;
      phase_nxt = phase_r;
      pwr_nxt = pwr_r;
      unique case (state_r)
         ST_IDLE: begin
            // a fall with select high is ignored; the wait for the
            // reference after shutdown is the host's burden
            if (fall && !i_rd_conv) begin
               state_nxt = ST_ACQ;
               pwr_nxt.powered = 1'b1;
               pwr_nxt.ref_on = 1'b1;
               pwr_nxt.track = 1'b1;
               eoc_n_nxt = 1'b1;
               phase_nxt = PHASE_CONV;
            end
         end
         ST_ACQ: begin
            // the select level here picks standby or shutdown for later
            if (fall) begin
               state_nxt = ST_CONV;
               pwr_nxt.track = 1'b0;
               shut_nxt = i_rd_conv;
               phase_nxt = PHASE_READ;
            end
         end
         ST_CONV: begin
            // converter ignores the strobe while busy
            if (sar_done) begin
               state_nxt = ST_DONE;
               eoc_n_nxt = 1'b0;
               dout_nxt = sar_result;
               pwr_nxt.powered = 1'b0;
               pwr_nxt.ref_on = !shut_r;
            end
         end
         ST_DONE: begin
            // a fall with select low is refused and the result stays put
            if (fall && i_rd_conv) begin
               state_nxt = ST_READ;
               oe_nxt = 1'b1;
            end
         end
         ST_READ: begin
            // the read ends on the strobe rise, not on a timer
            if (rise) begin
               state_nxt = ST_IDLE;
               oe_nxt = 1'b0;
               phase_nxt = PHASE_ACQ;
            end
         end
      endcase
   end

   // ***********************************************
   // sequencer registers
   // ***********************************************
   // reset puts everything back to idle at once; no phase survives it
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_r <= ST_IDLE;
         shut_r <= 1'b0;
         dout_r <= RESULT_RST;
         oe_r <= 1'b0;
         eoc_n_r <= 1'b1;
         phase_r <= PHASE_ACQ;
         pwr_r <= '0;
         trial_r <= '0;
      end else begin
         state_r <= state_nxt;
         shut_r <= shut_nxt;
         dout_r <= dout_nxt;
         oe_r <= oe_nxt;
         eoc_n_r <= eoc_n_nxt;
         phase_r <= phase_nxt;
         pwr_r <= pwr_nxt;
         trial_r <= sar_trial;
      end
   end

   // ***********************************************
   // outputs, all from flops
   // ***********************************************
   // bus floats in every state but read
   assign o_result_bus_o = dout_r;
   assign o_result_bus_oe = {RES_W{oe_r}};
   assign o_eoc_n = eoc_n_r;
   assign o_trial_dac = trial_r;
   assign o_power = pwr_r;
   assign o_phase = phase_r;

   // ***********************************************
   // checks
   // ***********************************************
   // cycles spent converting, held against the time limit
   int conv_cnt;
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || state_r != ST_CONV)
         conv_cnt <= 0;
      else
         conv_cnt <= conv_cnt + 1;
   end

   conv_time_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      conv_cnt <= CONV_MAX_CYC)
      else $error("conversion exceeds its time limit");

   bus_float_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_ACQ || state_r == ST_CONV) |-> !o_result_bus_oe[0])
      else $error("bus driven during acquire or convert");

   ignore_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_IDLE && fall && i_rd_conv) |=> state_r == ST_IDLE)
      else $error("select-high edge not ignored");

   acq_start_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_IDLE && fall && !i_rd_conv) |=> o_power.track && o_power.ref_on)
      else $error("acquisition did not begin");

   hold_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_ACQ && fall) |=> !o_power.track && state_r == ST_CONV)
      else $error("hold did not open on second edge");

   mode_pick_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      $fell(o_eoc_n) |-> (o_power.ref_on == !shut_r) && !o_power.powered)
      else $error("wrong power mode after conversion");

   read_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_DONE && fall && i_rd_conv) |=> o_result_bus_oe[0] && o_result_bus_o == $past(dout_r))
      else $error("result not driven on read edge");

   float_back_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_READ && rise) |=> !o_result_bus_oe[0] && o_phase == PHASE_ACQ)
      else $error("bus not released on strobe rise");

   reset_idle_a: assert property (@(posedge i_ref_clk)
      i_srst |=> state_r == ST_IDLE && o_eoc_n && !o_result_bus_oe[0])
      else $error("reset did not return to idle");

   // ***********************************************
   // checks of acquire and convert
   // ***********************************************
   // acquisition keeps the core powered and the hold closed
   acq_power_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_ACQ) |-> o_power.powered && o_power.track)
      else $error("acquire without power or tracking");

   // the acquire edge clears the done flag and moves the phase on
   phase_acq_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_IDLE && fall && !i_rd_conv) |=> o_phase == PHASE_CONV && o_eoc_n)
      else $error("acquire edge did not advance the phase");

   // the convert edge moves the phase on to read
   phase_conv_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_ACQ && fall) |=> o_phase == PHASE_READ)
      else $error("convert edge did not advance the phase");

   // the select level at the convert edge picks the mode
   mode_latch_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_ACQ && fall) |=> shut_r == $past(i_rd_conv))
      else $error("power mode not taken at the convert edge");

   // strobe edges are ignored until the engine finishes
   conv_deaf_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_CONV && !sar_done) |=> state_r == ST_CONV)
      else $error("conversion left before the engine finished");

   // the hold stays open from the convert edge to the read
   hold_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_CONV || state_r == ST_DONE) |-> !o_power.track)
      else $error("hold closed before the result was read");

   // nothing tracks while the sequencer waits for a strobe
   idle_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_IDLE) |-> !o_power.track && !o_power.powered)
      else $error("core awake while idle");

   // the engine only reports done inside a conversion
   done_only_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      sar_done |-> state_r == ST_CONV)
      else $error("engine done outside a conversion");

   // the done flag stays high until the engine has finished
   eoc_wait_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_ACQ || state_r == ST_CONV) |-> o_eoc_n)
      else $error("end of conversion shown too early");

   // ***********************************************
   // checks of result and read
   // ***********************************************
   // finishing drops the done flag and lands in the wait for a read
   eoc_fall_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_CONV && sar_done) |=> !o_eoc_n && state_r == ST_DONE)
      else $error("end of conversion not shown");

   // the done flag stands until the next acquire edge
   eoc_stand_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_DONE || state_r == ST_READ) |-> !o_eoc_n)
      else $error("end of conversion withdrawn early");

   // powering down follows every conversion without a host request
   power_auto_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_CONV && sar_done) |=> !o_power.powered && !o_power.track)
      else $error("core still powered after conversion");

   // a fall with select low while done is refused
   done_refuse_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_DONE && fall && !i_rd_conv) |=> state_r == ST_DONE && o_result_bus_oe == '0)
      else $error("convert-select fall drove the bus");

   // every bit is driven together for the whole read
   read_stand_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_READ) |-> o_result_bus_oe == '1)
      else $error("result bus not fully driven in read");

   // the word on the bus does not move while it is read
   result_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_READ) |-> $stable(o_result_bus_o))
      else $error("result changed while driven");

   // the bus floats while waiting for a strobe or a read
   idle_float_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_IDLE || state_r == ST_DONE) |-> o_result_bus_oe == '0)
      else $error("bus driven outside the read");

   // the read phase is announced until the read ends
   phase_read_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_CONV || state_r == ST_DONE) |-> o_phase == PHASE_READ)
      else $error("phase lost before the read");

   // reset also clears the power state and the phase
   reset_out_a: assert property (@(posedge i_ref_clk)
      i_srst |=> o_phase == PHASE_ACQ && o_power == '0)
      else $error("reset left power or phase set");
endmodule

// ### verification/sps_host_model.sv
`timescale 1ns/1ps
module sps_host_model
   import sps_pkg::*;
#(
   parameter int WAKE_CYC = 100
) (
   input wire logic i_ref_clk,
   input wire logic [RES_W-1:0] i_trial,
   input wire logic [RES_W-1:0] i_bus_o,
   input wire logic [RES_W-1:0] i_bus_oe,
   output logic o_start_n,
   output logic o_rd_conv,
   output logic o_cmp_hi,
   output logic [RES_W-1:0] o_bus_seen
);
   logic [RES_W-1:0] sample_r = 14'h0000;
   logic [RES_W-1:0] last_r = 14'h0000;
   logic shut_r = 1'b0;

   // ***********************************************
   // strobe driver
   // ***********************************************
   initial begin
      o_start_n = 1'b1;
      o_rd_conv = 1'b0;
   end

   // one strobe fall, held until the design has answered
   task automatic fall(input logic rd);
      @(posedge i_ref_clk);
      o_start_n <= 1'b0;
      o_rd_conv <= rd;
      repeat (2) @(posedge i_ref_clk);
      #1;
   endtask

   // strobe back high, which also keeps the falls apart
   task automatic rise();
      @(posedge i_ref_clk);
      o_start_n <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #1;
   endtask

   // wake wait is scaled down from milliseconds to keep runs short
   task automatic convert(input logic mode, input logic [RES_W-1:0] s);
      if (shut_r) repeat (WAKE_CYC) @(posedge i_ref_clk);
      sample_r = s;
      shut_r = mode;
      fall(mode);
   endtask

   // ***********************************************
   // analog side and bus
   // ***********************************************
   // comparator against the held sample
   assign o_cmp_hi = (sample_r >= i_trial);
   // a released bit shows the inverse of its last level, never a lucky match
   assign o_bus_seen = (i_bus_o & i_bus_oe) | (~last_r & ~i_bus_oe);
   always @(posedge i_ref_clk) last_r <= o_bus_seen;
endmodule

// ### verification/sar_adc_parallel_sequencer_tb.sv
`timescale 1ns/1ps
module sar_adc_parallel_sequencer_tb;
   import sps_pkg::*;
   localparam int STEP = 4;
   localparam int LIMIT = 20000;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic start_n, rd_conv, cmp_hi, eoc_n;
   logic [RES_W-1:0] bus_o, bus_oe, trial, bus_seen, s;
   sps_power_s power;
   logic [1:0] phase;
   int error_cnt = 0;
   int total_checks = 0;
   int cycles = 0;
   int seed = 59818;
   int n;

   always #4 i_ref_clk = ~i_ref_clk;

   sps_sequencer #(.STEP_DIV(STEP)) dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_start_n(start_n),
      .i_rd_conv(rd_conv), .i_cmp_hi(cmp_hi), .o_result_bus_o(bus_o), .o_result_bus_oe(bus_oe),
      .o_eoc_n(eoc_n), .o_trial_dac(trial), .o_power(power), .o_phase(phase));
   sps_host_model host (.i_ref_clk(i_ref_clk), .i_trial(trial), .i_bus_o(bus_o), .i_bus_oe(bus_oe),
      .o_start_n(start_n), .o_rd_conv(rd_conv), .o_cmp_hi(cmp_hi), .o_bus_seen(bus_seen));

   // ***********************************************
   // checking and reporting
   // ***********************************************
   task automatic chk_word(input string what, input logic [RES_W-1:0] exp, input logic [RES_W-1:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_ctl(input string what, input logic [3:0] exp, input logic [3:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // binary search against an ideal comparator
   function automatic logic [RES_W-1:0] sar_expect(input logic [RES_W-1:0] smp);
      logic [RES_W-1:0] r;
      r = '0;
      for (int i = RES_W - 1; i >= 0; i--) begin
         if (smp >= (r | (14'h0001 << i))) r = r | (14'h0001 << i);
      end
      return r;
   endfunction

   // hang guard, sized well above the planned cycles
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         error_cnt++;
         conclude();
      end
   end

   // ***********************************************
   // one full acquire, convert, read cycle
   // ***********************************************
   task automatic run_cycle(input logic mode, input logic [RES_W-1:0] smp);
      host.fall(1'b0);
      chk_ctl("phase", 4'h1, {2'h0, phase});
      chk_ctl("power", 4'h7, {1'b0, power});
      chk_word("oe", 14'h0000, bus_oe);
      host.rise();
      host.convert(mode, smp);
      chk_ctl("phase", 4'h2, {2'h0, phase});
      chk_ctl("track", 4'h0, {3'h0, power.track});
      host.rise();
      // stray fall mid-conversion must be ignored
      host.fall(1'b0);
      chk_ctl("phase", 4'h2, {2'h0, phase});
      host.rise();
      n = 0;
      while (eoc_n !== 1'b0 && n < CONV_MAX_CYC) begin
         @(posedge i_ref_clk);
         n++;
      end
      #1;
      chk_ctl("eoc", 4'h0, {3'h0, eoc_n});
      chk_ctl("power", {2'h0, ~mode, 1'b0}, {1'b0, power});
      chk_word("oe", 14'h0000, bus_oe);
      // fall with convert select while done is refused
      host.fall(1'b0);
      chk_word("oe", 14'h0000, bus_oe);
      host.rise();
      host.fall(1'b1);
      chk_word("oe", 14'h3fff, bus_oe);
      chk_word("data", sar_expect(smp), bus_seen);
      host.rise();
      chk_word("oe", 14'h0000, bus_oe);
      chk_ctl("phase", 4'h0, {2'h0, phase});
   endtask

   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      @(posedge i_ref_clk);
      #1;
      chk_ctl("reset", 4'h3, {1'b0, bus_oe[0], phase == 2'h0, eoc_n});
      $display("test reset done");
      host.fall(1'b1);
      chk_ctl("phase", 4'h0, {2'h0, phase});
      chk_ctl("power", 4'h0, {1'b0, power});
      host.rise();
      $display("test idle_ignore done");
      run_cycle(1'b1, 14'h0000);
      run_cycle(1'b0, 14'h3fff);
      run_cycle(1'b1, 14'h2aaa);
      $display("test corner cycles done");
      for (int k = 0; k < 6; k++) begin
         s = 14'($random(seed));
         run_cycle(s[5], s);
         $display("test cycle %0d done", k);
      end
      // reset in mid-conversion with the strobe high
      host.fall(1'b0);
      host.rise();
      s = 14'($random(seed));
      host.convert(s[2], s);
      host.rise();
      @(posedge i_ref_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      @(posedge i_ref_clk);
      #1;
      chk_ctl("reset", 4'h3, {1'b0, power.powered, phase == 2'h0, eoc_n});
      host.fall(1'b0);
      chk_ctl("phase", 4'h1, {2'h0, phase});
      host.rise();
      $display("test reset_mid done");
      conclude();
   end
endmodule
